/* File: rtl/rst_seq_pkg.sv */
package rst_seq_pkg;
	// ==========================================
	// timing
	localparam int CLK_PERIOD_NS = 100;
	// one state time is half a cpu clock period
	localparam int STATE_TIMES_PER_SEQ = 1024;
	localparam int SEQ_CYCLES = STATE_TIMES_PER_SEQ / 2;
	localparam int TRANSITION_CYCLES = 4;
	localparam int CNT_W = 10;
	localparam logic [CNT_W-1:0] SEQ_LAST = CNT_W'(SEQ_CYCLES - 1);
	localparam logic [CNT_W-1:0] TRANS_LAST = CNT_W'(TRANSITION_CYCLES - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
	// position of the bidirectional reset enable in the system config word
	localparam int BIDIR_RESET_ENABLE_BIT = 3;

	// ==========================================
	// reset sequencer states
	typedef enum logic [5:0] {
		ST_RUN = 6'h01,
		ST_HOLD = 6'h02,
		ST_BUS_WAIT = 6'h04,
		ST_TRANS = 6'h08,
		ST_SEQ = 6'h10,
		ST_EXTEND = 6'h20
	} rst_state_t;

	// power modes
	typedef enum logic [2:0] {
		PM_ACTIVE = 3'h1,
		PM_IDLE = 3'h2,
		PM_PDOWN = 3'h4
	} pwr_state_t;
endpackage

/* File: rtl/rst_sync.sv */
`timescale 1ns/1ps
// ==========================================
// two-stage synchroniser for the reset pin release
module rst_sync
	import rst_seq_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic async_in,
	output logic sync_out
);
	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;

	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	// first flop only feeds the second flop
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;
endmodule // rst_sync

/* File: rtl/reset_and_power_mode_sequencer.sv */
`timescale 1ns/1ps
// Summary of operation
// - asynchronous reset enters default state without any clock edge
// - release of the reset input pin is synchronised before leaving reset
// - warm reset starts when reset pin low and programming voltage high
// - warm reset tristates I/O at once and drives reset output low
// - after release a short transition cancels holds and aborts bus cycles
// - internal reset sequence then lasts 1024 state times, 512 clocks
// - with bidir enable set, drive reset pin low during the sequence
// - bidir enable is cleared at the end of every reset sequence unless set again in that same cycle
// - if reset pin still low after sequence, extend reset until released
// - software reset instruction starts the reset sequence from ST_RUN when no warm reset is pending
// - software reset with bidir enable drives pin low for 1024 state times
// - watchdog overflow starts the reset sequence
// - watchdog reset completes bus cycle without ready or ready low
// - watchdog reset aborts bus cycle when ready sampled high
// - no watchdog reset while in bootstrap loader mode
// - bidir reset shows watchdog and software reset as external reset
// - idle mode halts cpu while peripherals keep running
// - idle mode ends on any reset or interrupt request
// - power-down stops cpu and all peripherals
// - power-down ends only on a reset of any source or fast external interrupt
// - outstanding bus actions complete before idle or power-down entry
// - no entry when ready enabled but not activated on last access
module reset_and_power_mode_sequencer
	import rst_seq_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic reset_input_pin_n,
	input wire logic prog_voltage_high,
	input wire logic software_reset_instruction,
	input wire logic watchdog_overflow,
	input wire logic bootstrap_mode,
	input wire logic bidir_enable_set,
	input wire logic bus_cycle_active,
	input wire logic bus_uses_ready,
	input wire logic bus_waitstates_done,
	input wire logic ready_n,
	input wire logic last_ready_seen,
	input wire logic idle_req,
	input wire logic pdown_req,
	input wire logic interrupt_req,
	input wire logic fast_ext_int,
	output logic reset_output_pin_n,
	output logic reset_pin_drive_n,
	output logic reset_pin_oe_n,
	output logic io_tristate,
	output logic internal_reset,
	output logic bus_abort,
	output logic cancel_hold,
	output logic bidir_reset_enable,
	output logic cpu_run,
	output logic periph_run,
	output logic idle_mode,
	output logic pdown_mode
);
	// ==========================================
	// reset sequencer
	rst_state_t st_q, st_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic bidir_q, bidir_d;
	logic drive_q, drive_d;
	logic reset_output_pin_n_q, reset_output_pin_n_d;
	logic iorst_q, iorst_d;
	logic intrst_q, intrst_d;
	logic abort_q, abort_d;
	logic cancel_q, cancel_d;
	logic pin_rel;
	logic pin_low;
	logic wd_ok;

	rst_sync u_sync (
		.clk(clk),
		.rst(rst),
		.async_in(reset_input_pin_n),
		.sync_out(pin_rel)
	);

	// warm reset needs the programming pin high
	assign pin_low = !pin_rel && prog_voltage_high && !drive_q;
	assign wd_ok = watchdog_overflow && !bootstrap_mode;

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		bidir_d = bidir_q;
		drive_d = 1'b0;
		reset_output_pin_n_d = reset_output_pin_n_q;
		iorst_d = iorst_q;
		intrst_d = intrst_q;
		abort_d = 1'b0;
		cancel_d = 1'b0;
		if (bidir_enable_set) begin
			bidir_d = 1'b1;
		end
		case (st_q)
			ST_RUN: begin
				if (pin_low) begin
					st_d = ST_HOLD;
					reset_output_pin_n_d = 1'b0;
					iorst_d = 1'b1;
					intrst_d = 1'b1;
				end else if (software_reset_instruction) begin
					st_d = ST_TRANS;
					cnt_d = CNT_ZERO;
					reset_output_pin_n_d = 1'b0;
					intrst_d = 1'b1;
				end else if (wd_ok) begin
					st_d = ST_BUS_WAIT;
					reset_output_pin_n_d = 1'b0;
				end
			end
			ST_HOLD: begin
				if (pin_rel) begin
					st_d = ST_TRANS;
					cnt_d = CNT_ZERO;
				end
			end
			ST_BUS_WAIT: begin
				// finish cycle without ready or with ready low
				if (!bus_cycle_active ||
						(bus_waitstates_done && (!bus_uses_ready || !ready_n))) begin
					st_d = ST_TRANS;
					cnt_d = CNT_ZERO;
					intrst_d = 1'b1;
				end else if (bus_waitstates_done && ready_n) begin
					abort_d = 1'b1;
					st_d = ST_TRANS;
					cnt_d = CNT_ZERO;
					intrst_d = 1'b1;
				end
			end
			ST_TRANS: begin
				cancel_d = 1'b1;
				abort_d = 1'b1;
				if (cnt_q == TRANS_LAST) begin
					st_d = ST_SEQ;
					cnt_d = CNT_ZERO;
					drive_d = bidir_q;
				end else begin
					cnt_d = cnt_q + 10'h001;
				end
			end
			ST_SEQ: begin
				intrst_d = 1'b1;
				// bidir drive of the reset pin
				drive_d = bidir_q;
				if (cnt_q == SEQ_LAST) begin
					drive_d = 1'b0;
					// clear enable, a same-cycle set still wins
					bidir_d = bidir_enable_set;
					st_d = ST_EXTEND;
				end else begin
					cnt_d = cnt_q + 10'h001;
				end
			end
			ST_EXTEND: begin
				// hold while the synchronised pin still reads low
				if (pin_rel) begin
					st_d = ST_RUN;
					intrst_d = 1'b0;
					iorst_d = 1'b0;
					reset_output_pin_n_d = 1'b1;
				end
			end
			default: st_d = ST_RUN;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= ST_HOLD;
			cnt_q <= CNT_ZERO;
			bidir_q <= 1'b0;
			drive_q <= 1'b0;
			reset_output_pin_n_q <= 1'b0;
			iorst_q <= 1'b1;
			intrst_q <= 1'b1;
			abort_q <= 1'b0;
			cancel_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			bidir_q <= bidir_d;
			drive_q <= drive_d;
			reset_output_pin_n_q <= reset_output_pin_n_d;
			iorst_q <= iorst_d;
			intrst_q <= intrst_d;
			abort_q <= abort_d;
			cancel_q <= cancel_d;
		end
	end

	// ==========================================
	// power modes
	pwr_state_t pm_q, pm_d;
	logic idle_pend_q, idle_pend_d;
	logic pdown_pend_q, pdown_pend_d;
	logic can_enter;
	logic in_reset;
	logic cpu_run_q, cpu_run_d;
	logic periph_run_q, periph_run_d;
	logic idle_mode_q, idle_mode_d;
	logic pdown_mode_q, pdown_mode_d;

	assign in_reset = (st_q != ST_RUN);
	assign can_enter = !bus_cycle_active && last_ready_seen;

	always_comb begin
		pm_d = pm_q;
		idle_pend_d = idle_pend_q || idle_req;
		pdown_pend_d = pdown_pend_q || pdown_req;
		case (pm_q)
			PM_ACTIVE: begin
				if (pdown_pend_q && can_enter) begin
					pm_d = PM_PDOWN;
					pdown_pend_d = 1'b0;
					idle_pend_d = 1'b0;
				end else if (idle_pend_q && can_enter) begin
					pm_d = PM_IDLE;
					idle_pend_d = 1'b0;
				end
			end
			PM_IDLE: begin
				if (interrupt_req) begin
					pm_d = PM_ACTIVE;
				end
			end
			PM_PDOWN: begin
				if (fast_ext_int) begin
					pm_d = PM_ACTIVE;
				end
			end
			default: pm_d = PM_ACTIVE;
		endcase
		// any reset ends the mode and cancels requests
		if (in_reset || pin_low) begin
			pm_d = PM_ACTIVE;
			idle_pend_d = 1'b0;
			pdown_pend_d = 1'b0;
		end
		// registered decode keeps the run enables glitch free
		cpu_run_d = (pm_d == PM_ACTIVE) && !intrst_d;
		periph_run_d = (pm_d != PM_PDOWN);
		idle_mode_d = (pm_d == PM_IDLE);
		pdown_mode_d = (pm_d == PM_PDOWN);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pm_q <= PM_ACTIVE;
			idle_pend_q <= 1'b0;
			pdown_pend_q <= 1'b0;
			cpu_run_q <= 1'b0;
			periph_run_q <= 1'b1;
			idle_mode_q <= 1'b0;
			pdown_mode_q <= 1'b0;
		end else begin
			pm_q <= pm_d;
			idle_pend_q <= idle_pend_d;
			pdown_pend_q <= pdown_pend_d;
			cpu_run_q <= cpu_run_d;
			periph_run_q <= periph_run_d;
			idle_mode_q <= idle_mode_d;
			pdown_mode_q <= pdown_mode_d;
		end
	end

	// ==========================================
	// outputs, all from flops except the constant reset_pin_drive_n
	assign reset_output_pin_n = reset_output_pin_n_q;
	assign reset_pin_drive_n = 1'b0;
	assign reset_pin_oe_n = !drive_q;
	assign io_tristate = iorst_q;
	assign internal_reset = intrst_q;
	assign bus_abort = abort_q;
	assign cancel_hold = cancel_q;
	assign bidir_reset_enable = bidir_q;
	assign cpu_run = cpu_run_q;
	assign periph_run = periph_run_q;
	assign idle_mode = idle_mode_q;
	assign pdown_mode = pdown_mode_q;

	// ==========================================
	// checks
	logic [CNT_W:0] drv_len_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			drv_len_q <= 11'h000;
		end else begin
			drv_len_q <= drive_q ? drv_len_q + 11'h001 : 11'h000;
		end
	end

	property p_seq_len;
		@(posedge clk) disable iff (rst)
		$fell(drive_q) |-> drv_len_q == 11'(SEQ_CYCLES);
	endproperty
	a_seq_len: assert property (p_seq_len) else $error("drive length wrong");

	property p_warm;
		@(posedge clk) disable iff (rst)
		(st_q == ST_RUN && pin_low) |=> (!reset_output_pin_n_q && iorst_q);
	endproperty
	a_warm: assert property (p_warm) else $error("warm entry missed");

	property p_sw;
		@(posedge clk) disable iff (rst)
		(st_q == ST_RUN && !pin_low && software_reset_instruction)
			|=> st_q == ST_TRANS ##4 st_q == ST_SEQ;
	endproperty
	a_sw: assert property (p_sw) else $error("sw reset not sequenced");

	property p_bd_clr;
		@(posedge clk) disable iff (rst)
		(st_q == ST_SEQ && cnt_q == SEQ_LAST && !bidir_enable_set)
			|=> !bidir_q;
	endproperty
	a_bd_clr: assert property (p_bd_clr) else $error("bidir not cleared");

	property p_boot;
		@(posedge clk) disable iff (rst)
		(st_q == ST_RUN && bootstrap_mode && !software_reset_instruction
			&& !pin_low) |=> st_q != ST_BUS_WAIT;
	endproperty
	a_boot: assert property (p_boot) else $error("wd in bootstrap");

	property p_extend;
		@(posedge clk) disable iff (rst)
		(st_q == ST_EXTEND && !pin_rel) |=> intrst_q;
	endproperty
	a_extend: assert property (p_extend) else $error("reset not held");

	property p_entry;
		@(posedge clk) disable iff (rst)
		(pm_q == PM_ACTIVE && !can_enter) |=> pm_q == PM_ACTIVE;
	endproperty
	a_entry: assert property (p_entry) else $error("bad mode entry");

	property p_pdown;
		@(posedge clk) disable iff (rst)
		(pm_q == PM_PDOWN && !fast_ext_int && !in_reset && !pin_low)
			|=> pm_q == PM_PDOWN;
	endproperty
	a_pdown: assert property (p_pdown) else $error("pdown left early");

	property p_abort;
		@(posedge clk) disable iff (rst)
		(st_q == ST_BUS_WAIT && bus_cycle_active && bus_waitstates_done
			&& bus_uses_ready && ready_n) |=> bus_abort;
	endproperty
	a_abort: assert property (p_abort) else $error("no abort");
endmodule // reset_and_power_mode_sequencer

/* File: tb/ext_reset_partner.sv */
`timescale 1ns/1ps
// ==========================================
// external reset circuit: open-drain reset pin with a pull-up
module ext_reset_partner (
	input wire logic hold_low,
	input wire logic oe_n,
	input wire logic drive_n,
	output logic pin_n
);
	// pull-up wins unless either side pulls the pin low
	assign pin_n = (hold_low || (!oe_n && !drive_n)) ? 1'b0 : 1'b1;
endmodule // ext_reset_partner

/* File: tb/reset_and_power_mode_sequencer_tb.sv */
`timescale 1ns/1ps
module reset_and_power_mode_sequencer_tb;
	import rst_seq_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hold_low, pin_n, prog_voltage_high, software_reset_instruction;
	logic watchdog_overflow, bootstrap_mode, bidir_enable_set;
	logic bus_cycle_active, bus_uses_ready, bus_waitstates_done, ready_n;
	logic last_ready_seen, idle_req, pdown_req, interrupt_req, fast_ext_int;
	logic reset_output_pin_n, reset_pin_drive_n, reset_pin_oe_n, io_tristate;
	logic internal_reset, bus_abort, cancel_hold, bidir_reset_enable;
	logic cpu_run, periph_run, idle_mode, pdown_mode;
	int failures = 0;
	int total_checks = 0;
	int low_cnt = 0;
	int seed;
	int notes[$];

	always #50 clk = ~clk;

	reset_and_power_mode_sequencer i_reset_and_power_mode_sequencer (
		.clk(clk), .rst(rst), .reset_input_pin_n(pin_n),
		.prog_voltage_high(prog_voltage_high),
		.software_reset_instruction(software_reset_instruction),
		.watchdog_overflow(watchdog_overflow), .bootstrap_mode(bootstrap_mode),
		.bidir_enable_set(bidir_enable_set),
		.bus_cycle_active(bus_cycle_active), .bus_uses_ready(bus_uses_ready),
		.bus_waitstates_done(bus_waitstates_done), .ready_n(ready_n),
		.last_ready_seen(last_ready_seen), .idle_req(idle_req),
		.pdown_req(pdown_req), .interrupt_req(interrupt_req),
		.fast_ext_int(fast_ext_int), .reset_output_pin_n(reset_output_pin_n),
		.reset_pin_drive_n(reset_pin_drive_n), .reset_pin_oe_n(reset_pin_oe_n),
		.io_tristate(io_tristate), .internal_reset(internal_reset),
		.bus_abort(bus_abort), .cancel_hold(cancel_hold),
		.bidir_reset_enable(bidir_reset_enable), .cpu_run(cpu_run),
		.periph_run(periph_run), .idle_mode(idle_mode), .pdown_mode(pdown_mode)
	);

	ext_reset_partner i_ext_reset_partner (
		.hold_low(hold_low), .oe_n(reset_pin_oe_n),
		.drive_n(reset_pin_drive_n), .pin_n(pin_n)
	);

	// ==========================================
	// helpers
	task check(input string name, input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %0h seen %0h", name, exp, got);
		end
	endtask

	task wrap_up;
		if (failures == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ready toggles randomly while no bus cycle depends on it
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
		if (!bus_cycle_active)
			ready_n = 1'($random(seed));
	endtask

	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask

	task wait_released;
		int k;
		for (k = 0; k < 2000 && internal_reset !== 1'b0; k++)
			tick(1);
		if (k == 2000) begin
			failures++;
			wrap_up();
		end
		tick(2);
	endtask

	// ==========================================
	// monitor: length of each own pin drive against the oldest note
	// sampled mid-cycle so the count never races the launching edge
	always @(negedge clk) begin
		if (reset_pin_oe_n === 1'b0)
			low_cnt++;
		else if (low_cnt != 0) begin
			check("pin drive length", low_cnt, notes.pop_front());
			low_cnt = 0;
		end
	end

	// ==========================================
	// stimulus
	initial begin
		seed = 32'h1A6E61A6;
		{prog_voltage_high, last_ready_seen} = 2'b11;
		{software_reset_instruction, watchdog_overflow, bootstrap_mode} = 3'h0;
		{bidir_enable_set, bus_cycle_active, bus_uses_ready} = 3'h0;
		{bus_waitstates_done, ready_n, idle_req, pdown_req} = 4'h0;
		{interrupt_req, fast_ext_int, hold_low} = 3'h0;
		tick(8);
		rst = 1'b0;
		wait_released();
		check("cpu_run", cpu_run, 1'b1);
		check("io_tristate", io_tristate, 1'b0);
		// software reset with bidirectional drive
		pulse(bidir_enable_set);
		check("bidir set", bidir_reset_enable, 1'b1);
		notes.push_back(SEQ_CYCLES);
		pulse(software_reset_instruction);
		check("reset_output_pin", reset_output_pin_n, 1'b0);
		check("internal_reset", internal_reset, 1'b1);
		wait_released();
		check("bidir cleared", bidir_reset_enable, 1'b0);
		// warm reset from the pin
		pulse(bidir_enable_set);
		hold_low = 1'b1;
		tick(5);
		check("warm reset_output_pin", reset_output_pin_n, 1'b0);
		check("warm tristate", io_tristate, 1'b1);
		notes.push_back(SEQ_CYCLES);
		hold_low = 1'b0;
		wait_released();
		check("bidir cleared", bidir_reset_enable, 1'b0);
		// pin still low after the sequence prolongs reset
		pulse(software_reset_instruction);
		tick(10);
		hold_low = 1'b1;
		tick(600);
		check("extended", internal_reset, 1'b1);
		hold_low = 1'b0;
		wait_released();
		// watchdog masked in bootstrap, then aborting a bus cycle
		bootstrap_mode = 1'b1;
		pulse(watchdog_overflow);
		tick(2);
		check("boot wd", reset_output_pin_n, 1'b1);
		bootstrap_mode = 1'b0;
		{bus_cycle_active, bus_uses_ready, bus_waitstates_done} = 3'h7;
		ready_n = 1'b1;
		pulse(bidir_enable_set);
		notes.push_back(SEQ_CYCLES);
		pulse(watchdog_overflow);
		tick(1);
		check("wd abort", bus_abort, 1'b1);
		{bus_cycle_active, bus_uses_ready, bus_waitstates_done} = 3'h0;
		wait_released();
		// watchdog lets a cycle ended by ready finish without abort
		{bus_cycle_active, bus_uses_ready, bus_waitstates_done} = 3'h7;
		ready_n = 1'b0;
		pulse(watchdog_overflow);
		tick(1);
		check("wd no abort", bus_abort, 1'b0);
		check("wd reset", internal_reset, 1'b1);
		{bus_cycle_active, bus_uses_ready, bus_waitstates_done} = 3'h0;
		wait_released();
		// idle entry and interrupt exit
		pulse(idle_req);
		tick(1);
		check("idle", idle_mode, 1'b1);
		check("idle cpu", cpu_run, 1'b0);
		check("idle periph", periph_run, 1'b1);
		pulse(interrupt_req);
		tick(1);
		check("idle exit", idle_mode, 1'b0);
		// power-down refused, deferred, entered, woken
		last_ready_seen = 1'b0;
		pulse(pdown_req);
		tick(4);
		check("no ready", pdown_mode, 1'b0);
		bus_cycle_active = 1'b1;
		last_ready_seen = 1'b1;
		tick(4);
		check("bus busy", pdown_mode, 1'b0);
		bus_cycle_active = 1'b0;
		tick(3);
		check("pdown", pdown_mode, 1'b1);
		check("pdown periph", periph_run, 1'b0);
		pulse(interrupt_req);
		tick(3);
		check("pdown kept", pdown_mode, 1'b1);
		pulse(fast_ext_int);
		tick(3);
		check("pdown exit", pdown_mode, 1'b0);
		// asynchronous reset in mid-run while idle
		pulse(idle_req);
		tick(3);
		rst = 1'b1;
		#10 check("async rst", internal_reset, 1'b1);
		check("async tristate", io_tristate, 1'b1);
		tick(2);
		rst = 1'b0;
		wait_released();
		check("reset idle exit", idle_mode, 1'b0);
		check("notes left", notes.size(), 0);
		wrap_up();
	end
endmodule // reset_and_power_mode_sequencer_tb
